// File: rbwd_pkg.sv
package rbwd_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25000000; // system clock rate
    localparam int unsigned STUCK_S = 30; // stuck heartbeat limit, seconds
    localparam longint unsigned STUCK_CYC = longint'(STUCK_S) * CLK_HZ;
    localparam int unsigned PWRUP_US = 100; // power-up hold, microseconds
    localparam int unsigned PWRUP_CYC = PWRUP_US * (CLK_HZ / 1000000);

    // ------------------------------------------------------------
    // command layout
    // ------------------------------------------------------------
    localparam int CMD_W = 8; // width of one command byte
    localparam logic [7:0] CMD_SET_HEAT = 8'h01; // load heater bits
    localparam logic [7:0] CMD_SET_VALVE_A = 8'h02; // load valve unit 0
    localparam logic [7:0] CMD_SET_VALVE_B = 8'h03; // load valve unit 1
    localparam logic [7:0] CMD_SET_BEAT = 8'h04; // load heartbeat level

    // heater bit positions
    localparam int HEAT_CELL = 0; // reaction cell heater
    localparam int HEAT_CONV = 1; // converter heater
    localparam int HEAT_OVEN = 2; // permeation oven heater
    localparam int HEAT_W = 3; // heater count

    // indicator positions
    localparam int IND_BEAT = 0; // heartbeat
    localparam int IND_HEAT0 = 1; // first heater indicator
    localparam int IND_VALVE0 = 6; // first valve indicator
    localparam int IND_W = 16; // indicator count

    // reset values
    localparam logic [2:0] HEAT_RST = 3'h0; // all heaters off
    localparam logic [3:0] VALVE_RST = 4'h0; // all valves de-energized

    // watchdog states
    typedef enum logic [2:0] {
        RBWD_HOLD = 3'b001, // power-up hold
        RBWD_RUN = 3'b010, // host in control
        RBWD_TRIP = 3'b100 // outputs forced safe
    } rbwd_state_t;

endpackage

// File: rbwd_timer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// stuck level timer: counts while a level holds, flags at limit
// ------------------------------------------------------------
module rbwd_timer #(
    parameter longint unsigned LIMIT = 750000000, // cycles to expiry
    parameter int W = 32 // counter width
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic restart, // restart the count
    output logic expired // limit reached, level
);

    logic [W-1:0] cnt_q; // cycles since last restart

    // count up, saturate at limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (restart) begin
                cnt_q <= '0;
            end else if (cnt_q != W'(LIMIT)) begin
                cnt_q <= cnt_q + W'(1);
            end
        end
    end

    assign expired = (cnt_q == W'(LIMIT)) && !restart;

endmodule

// File: rbwd_top.sv
`timescale 1ns/1ps
// What this block does
// - heartbeat level set only by host commands
// - stuck heartbeat 30s forces valves shut, heaters off
// - outputs held fixed until host takes control
// - decode bus commands into relay outputs
// - sixteen indicators mirror outputs except valve unit 1 bit 3, spares dark
// - heaters switch on only by host command
// - valves default de-energized, energize selects alternative
// - two valve units, four outputs each
// - oven heater active only with span generator
module rbwd_top #(
    parameter longint unsigned STUCK_LIMIT = rbwd_pkg::STUCK_CYC, // trip
    parameter int unsigned HOLD_LIMIT = rbwd_pkg::PWRUP_CYC // hold time
) (
    input wire logic CLK_SYS, // system clock, 25 MHz
    input wire logic RST_N, // async reset, active low
    input wire logic CE, // clock enable, freezes state when low
    input wire logic CMD_VALID, // decoded bus byte pair strobe
    input wire logic [7:0] CMD_CODE, // command code
    input wire logic [7:0] CMD_DATA, // command data
    input wire logic HOST_READY, // host booted and in control
    input wire logic OVEN_FITTED, // span generator option fitted
    output logic [2:0] HEATER_ON, // heater relays, high heats
    output logic [3:0] VALVE_A, // valve unit 0, high energized
    output logic [3:0] VALVE_B, // valve unit 1, high energized
    output logic [15:0] INDICATOR, // status indicators, high lit
    output logic TRIPPED, // watchdog has forced safe state
    output logic HOLDING // power-up hold active
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rbwd_pkg::rbwd_state_t st_q; // watchdog state
    logic [2:0] heat_q; // commanded heaters
    logic [3:0] va_q; // commanded valve unit 0
    logic [3:0] vb_q; // commanded valve unit 1
    logic beat_q; // heartbeat level from host
    logic beat_prev_q; // heartbeat one cycle ago
    logic [15:0] hold_cnt_q; // power-up hold counter
    logic expired; // stuck timer expired
    logic cmd_ok; // command accepted this cycle

    // commands count only once host has control
    assign cmd_ok = CMD_VALID && (st_q == rbwd_pkg::RBWD_RUN);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // heaters and valves load from host bytes only
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            heat_q <= rbwd_pkg::HEAT_RST;
            va_q <= rbwd_pkg::VALVE_RST;
            vb_q <= rbwd_pkg::VALVE_RST;
        end else if (CE) begin
            if (st_q != rbwd_pkg::RBWD_RUN) begin
                // safe state, commands ignored
                heat_q <= rbwd_pkg::HEAT_RST;
                va_q <= rbwd_pkg::VALVE_RST;
                vb_q <= rbwd_pkg::VALVE_RST;
            end else if (cmd_ok) begin
                unique case (CMD_CODE)
                    rbwd_pkg::CMD_SET_HEAT: begin
                        heat_q <= CMD_DATA[2:0];
                    end
                    rbwd_pkg::CMD_SET_VALVE_A: begin
                        va_q <= CMD_DATA[3:0];
                    end
                    rbwd_pkg::CMD_SET_VALVE_B: begin
                        vb_q <= CMD_DATA[3:0];
                    end
                    default: begin
                        // other codes leave outputs alone
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // heartbeat
    // ------------------------------------------------------------
    // level only ever comes from a host command
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            beat_q <= 1'b0;
            beat_prev_q <= 1'b0;
        end else if (CE) begin
            if (cmd_ok && CMD_CODE == rbwd_pkg::CMD_SET_BEAT) begin
                beat_q <= CMD_DATA[0];
            end
            beat_prev_q <= beat_q;
        end
    end

    // stuck timer restarts on each edge and outside run
    rbwd_timer #(
        .LIMIT(STUCK_LIMIT),
        .W(32)
    ) u_timer (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .restart((beat_q != beat_prev_q) || st_q != rbwd_pkg::RBWD_RUN),
        .expired(expired)
    );

    // ------------------------------------------------------------
    // watchdog state machine
    // ------------------------------------------------------------
    // hold after reset, run under host, trip sticks until reset
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= rbwd_pkg::RBWD_HOLD;
            hold_cnt_q <= 16'h0000;
        end else if (CE) begin
            unique case (st_q)
                rbwd_pkg::RBWD_HOLD: begin
                    // wait out supply settle then host ready
                    if (hold_cnt_q != HOLD_LIMIT[15:0]) begin
                        hold_cnt_q <= hold_cnt_q + 16'h0001;
                    end else if (HOST_READY) begin
                        st_q <= rbwd_pkg::RBWD_RUN;
                    end
                end
                rbwd_pkg::RBWD_RUN: begin
                    if (expired) begin
                        st_q <= rbwd_pkg::RBWD_TRIP;
                    end
                end
                rbwd_pkg::RBWD_TRIP: begin
                    st_q <= rbwd_pkg::RBWD_TRIP;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs and indicators
    // ------------------------------------------------------------
    // registered outputs, oven gated by option strap
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HEATER_ON <= 3'h0;
            VALVE_A <= 4'h0;
            VALVE_B <= 4'h0;
            INDICATOR <= 16'h0000;
            TRIPPED <= 1'b0;
            HOLDING <= 1'b1;
        end else if (CE) begin
            HEATER_ON <= {heat_q[2] & OVEN_FITTED, heat_q[1:0]};
            VALVE_A <= va_q;
            VALVE_B <= vb_q;
            // spares d4 d6 d14-16 stay dark
            INDICATOR <= {3'h0, vb_q[2:0], va_q, 1'b0,
                heat_q[2] & OVEN_FITTED, 1'b0, heat_q[1:0], beat_q};
            TRIPPED <= (st_q == rbwd_pkg::RBWD_TRIP);
            HOLDING <= (st_q == rbwd_pkg::RBWD_HOLD);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_trip_safe;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (st_q == rbwd_pkg::RBWD_TRIP && CE) ##1 CE |=> (HEATER_ON == 3'h0
            && VALVE_A == 4'h0 && VALVE_B == 4'h0);
    endproperty
    a_trip_safe: assert property (p_trip_safe)
        else $error("outputs not safe after trip");

    property p_hold_safe;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (st_q == rbwd_pkg::RBWD_HOLD && CE) |=> (heat_q == 3'h0);
    endproperty
    a_hold_safe: assert property (p_hold_safe)
        else $error("heater energized during hold");

    property p_beat_cmd;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (beat_q != $past(beat_q)) |-> $past(cmd_ok && CE
            && CMD_CODE == rbwd_pkg::CMD_SET_BEAT);
    endproperty
    a_beat_cmd: assert property (p_beat_cmd)
        else $error("heartbeat changed without command");

    property p_edge_restart;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (CE && beat_q != beat_prev_q) |=> (u_timer.cnt_q == '0);
    endproperty
    a_edge_restart: assert property (p_edge_restart)
        else $error("timer not restarted on heartbeat change");

    property p_oven_gate;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (CE && !OVEN_FITTED) |=> !HEATER_ON[2];
    endproperty
    a_oven_gate: assert property (p_oven_gate)
        else $error("oven heater on without option");

    property p_heat_cmd;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (CE && cmd_ok && CMD_CODE == rbwd_pkg::CMD_SET_HEAT)
            |=> heat_q == $past(CMD_DATA[2:0]);
    endproperty
    a_heat_cmd: assert property (p_heat_cmd)
        else $error("heater command not applied");

    property p_valve_cmd;
        @(posedge CLK_SYS) disable iff (!RST_N)
        (CE && cmd_ok && CMD_CODE == rbwd_pkg::CMD_SET_VALVE_A)
            |=> va_q == $past(CMD_DATA[3:0]);
    endproperty
    a_valve_cmd: assert property (p_valve_cmd)
        else $error("valve command not applied");

    property p_ind_spare;
        @(posedge CLK_SYS) disable iff (!RST_N)
        1'b1 |-> (INDICATOR[3] == 1'b0 && INDICATOR[5] == 1'b0
            && INDICATOR[15:13] == 3'h0);
    endproperty
    a_ind_spare: assert property (p_ind_spare)
        else $error("spare indicator lit");

    c_trip: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        st_q == rbwd_pkg::RBWD_RUN ##1 st_q == rbwd_pkg::RBWD_TRIP);
    c_run: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        st_q == rbwd_pkg::RBWD_HOLD ##1 st_q == rbwd_pkg::RBWD_RUN);
    c_beat: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        beat_q != beat_prev_q);

endmodule

// File: rbwd_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// host model: transceiver output as command strobes
// ----------------------------------------
module rbwd_host (
    input wire logic clk, // system clock
    output logic valid, // command strobe
    output logic [7:0] code, // command code
    output logic [7:0] data, // command data
    output logic beat // heartbeat level last sent
);
    // idle bus at time zero
    initial begin
        valid = 1'b0;
        code = 8'h00;
        data = 8'h00;
        beat = 1'b0;
    end
    // one code and data byte per strobe; released fields inverted
    task automatic send(input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        valid <= 1'b1;
        code <= c;
        data <= d;
        @(posedge clk);
        valid <= 1'b0;
        code <= ~c;
        data <= ~d;
    endtask
    // two commands on consecutive edges
    task automatic send2(input logic [7:0] c1, input logic [7:0] d1,
                         input logic [7:0] c2, input logic [7:0] d2);
        @(posedge clk);
        valid <= 1'b1;
        code <= c1;
        data <= d1;
        @(posedge clk);
        code <= c2;
        data <= d2;
        @(posedge clk);
        valid <= 1'b0;
        code <= ~c2;
        data <= ~d2;
    endtask
    // heartbeat flips only through a bus command
    task automatic toggle();
        beat = ~beat;
        send(rbwd_pkg::CMD_SET_BEAT, {7'h00, beat});
    endtask
endmodule

// File: rbwd_top_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// self-checking bench for the relay board control
// ----------------------------------------
module rbwd_top_bench;
    localparam int unsigned STUCK = 200; // shortened trip count
    localparam int unsigned HOLD = 4; // shortened power-up hold
    logic clk_sys = 1'b0; // system clock
    logic rst_n = 1'b0; // reset, active low
    logic ce = 1'b1; // clock enable
    logic host_ready = 1'b0; // host booted
    logic oven_fitted = 1'b0; // span generator option
    logic cmd_valid; // command strobe from host
    logic [7:0] cmd_code; // command code
    logic [7:0] cmd_data; // command data
    logic [2:0] heater_on; // heater relays
    logic [3:0] valve_a; // valve unit 0
    logic [3:0] valve_b; // valve unit 1
    logic [15:0] indicator; // status indicators
    logic tripped; // watchdog tripped
    logic holding; // power-up hold
    logic [2:0] e_heat = 3'h0; // expected heaters
    logic [3:0] e_va = 4'h0; // expected valve unit 0
    logic [3:0] e_vb = 4'h0; // expected valve unit 1
    logic e_beat = 1'b0; // expected heartbeat indicator
    logic e_trip = 1'b0; // expected trip flag
    logic e_hold = 1'b1; // expected hold flag
    int error_cnt = 0; // mismatches
    int samples_checked = 0; // comparisons made

    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    rbwd_host host (.clk(clk_sys), .valid(cmd_valid), .code(cmd_code),
        .data(cmd_data), .beat());
    rbwd_top #(.STUCK_LIMIT(STUCK), .HOLD_LIMIT(HOLD)) dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .CMD_VALID(cmd_valid),
        .CMD_CODE(cmd_code), .CMD_DATA(cmd_data), .HOST_READY(host_ready),
        .OVEN_FITTED(oven_fitted), .HEATER_ON(heater_on), .VALVE_A(valve_a),
        .VALVE_B(valve_b), .INDICATOR(indicator), .TRIPPED(tripped),
        .HOLDING(holding));

    // verdict and end of run
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // compare one value
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // compare every output against the expected state
    task automatic chk_outs();
        chk("heater", {13'h0, e_heat}, {13'h0, heater_on});
        chk("valve_a", {12'h0, e_va}, {12'h0, valve_a});
        chk("valve_b", {12'h0, e_vb}, {12'h0, valve_b});
        chk("indicator", {3'h0, e_vb[2:0], e_va, 1'b0, e_heat[2], 1'b0,
            e_heat[1:0], e_beat}, indicator);
        chk("flags", {14'h0, e_trip, e_hold}, {14'h0, tripped, holding});
    endtask
    // let a command reach the output ports
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    task automatic run_all();
        repeat (5) @(posedge clk_sys);
        #1;
        chk_outs();
        @(posedge clk_sys);
        rst_n <= 1'b1;
        // command while held is refused
        host.send(rbwd_pkg::CMD_SET_HEAT, 8'h07);
        settle();
        chk_outs();
        @(posedge clk_sys);
        host_ready <= 1'b1;
        // bounded wait for the hold to end
        for (int i = 0; i < 20 && holding !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (holding !== 1'b0) begin
            // hold never ended: count it and go to the verdict
            chk("hold_end", 16'h0000, {15'h0, holding});
            return;
        end
        e_hold = 1'b0;
        host.toggle();
        e_beat = 1'b1;
        // oven stays off without the option
        host.send(rbwd_pkg::CMD_SET_HEAT, 8'h07);
        e_heat = 3'h3;
        settle();
        chk_outs();
        @(posedge clk_sys);
        oven_fitted <= 1'b1;
        host.send(rbwd_pkg::CMD_SET_HEAT, 8'h07);
        e_heat = 3'h7;
        settle();
        chk_outs();
        // both valve units back to back
        host.send2(rbwd_pkg::CMD_SET_VALVE_A, 8'h0A,
                   rbwd_pkg::CMD_SET_VALVE_B, 8'h0D);
        e_va = 4'hA;
        e_vb = 4'hD;
        settle();
        chk_outs();
        host.send(rbwd_pkg::CMD_SET_HEAT, 8'h00);
        e_heat = 3'h0;
        settle();
        chk_outs();
        // unknown code leaves everything alone
        host.send(8'h05, 8'hFF);
        settle();
        chk_outs();
        // strobe with clock enable low is not taken
        @(posedge clk_sys);
        ce <= 1'b0;
        host.send(rbwd_pkg::CMD_SET_HEAT, 8'h07);
        ce <= 1'b1;
        settle();
        chk_outs();
        // steady heartbeat outlasts the trip count in total
        for (int k = 0; k < 5; k++) begin
            host.toggle();
            e_beat = ~e_beat;
            settle();
            chk_outs();
            repeat (60) @(posedge clk_sys);
        end
        // heartbeat stuck: no trip early, trip soon after the limit
        host.toggle();
        e_beat = ~e_beat;
        repeat (STUCK - 20) @(posedge clk_sys);
        #1;
        chk("early_trip", 16'h0000, {15'h0, tripped});
        for (int i = 0; i < 40 && tripped !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (tripped !== 1'b1) begin
            // no trip in time: count it and go to the verdict
            chk("trip", 16'h0001, {15'h0, tripped});
            return;
        end
        settle();
        // trip clears relays and valves, heartbeat level stays shown
        e_heat = 3'h0;
        e_va = 4'h0;
        e_vb = 4'h0;
        e_trip = 1'b1;
        chk_outs();
        // commands after a trip are refused
        host.send(rbwd_pkg::CMD_SET_VALVE_A, 8'h0F);
        settle();
        chk_outs();
        // second reset clears the trip and runs the hold again
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        e_beat = 1'b0;
        e_trip = 1'b0;
        e_hold = 1'b1;
        chk_outs();
        @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 20 && holding !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        e_hold = 1'b0;
        chk_outs();
        // host regains control after the second hold
        host.send(rbwd_pkg::CMD_SET_HEAT, 8'h03);
        e_heat = 3'h3;
        settle();
        chk_outs();
    endtask

    // run the sequence, then the one verdict
    initial begin
        run_all();
        finish_test();
    end
endmodule
